// *** verilog/uirb_map.svh ***
// register indices, field positions, reset values and timing constants
`ifndef UIRB_MAP_SVH
`define UIRB_MAP_SVH
`define UIRB_IDX_MODE     8'h00
`define UIRB_IDX_FRAME    8'h01
`define UIRB_IDX_TRANSCEIVER_PIN_SETUP     8'h02
`define UIRB_IDX_SIP      8'h03
`define UIRB_IDX_MINRX    8'h04
`define UIRB_IDX_TRANSMIT_PULSE_WIDTH     8'h05
`define UIRB_IDX_FIFOCTL  8'h06
`define UIRB_IDX_STATUS   8'h07
`define UIRB_MODE_FIR     0
`define UIRB_MODE_SIR16   1
`define UIRB_MODE_BACK_TO_BACK_ENABLE    2
`define UIRB_MODE_RATE_LO 5
`define UIRB_MODE_RATE_HI 7
`define UIRB_MODE_PLL     8
`define UIRB_MODE_DTD     10
`define UIRB_MODE_DIR     11
`define UIRB_MODE_AUTO_PULSE_ENABLE   12
`define UIRB_MODE_SEND    13
`define UIRB_MODE_CHG     14
`define UIRB_MODE_RST     15
`define UIRB_TRANSCEIVER_PIN_SETUP_CFG     2
`define UIRB_TRANSCEIVER_PIN_SETUP_FAST    3
`define UIRB_TRANSCEIVER_PIN_SETUP_TRANSMIT_INVERT   10
`define UIRB_TRANSCEIVER_PIN_SETUP_RECEIVE_INVERT   11
`define UIRB_FIFO_CLR     15
`define UIRB_RST_MODE     16'h9524
`define UIRB_RST_FRAME    16'h0000
`define UIRB_RST_TRANSCEIVER_PIN_SETUP     12'h100
`define UIRB_RST_SIP      16'hAA4C
`define UIRB_RST_MINRX    16'h0000
`define UIRB_RST_TRANSMIT_PULSE_WIDTH     16'h0000
`define UIRB_RST_FIFOCTL  15'h400A
`define UIRB_RST_TRANSFER_ACTIVITY_STATUS     14'h000A
`define UIRB_CLK_HZ       20000000
`define UIRB_CLK_MHZ      20
`define UIRB_CLK_NS       50
`define UIRB_SIP_REF_MHZ  48
`define UIRB_SIR_PULSE_NS 1600
`define UIRB_SIR_FRAC_NUM 3
`define UIRB_SIR_FRAC_DEN 16
`define UIRB_SIR_PULSE_CYC ((`UIRB_SIR_PULSE_NS+`UIRB_CLK_NS-1)/`UIRB_CLK_NS)
`define UIRB_FIR_HZ       4000000
`define UIRB_TIMEOUT_MS   50
`define UIRB_TIMEOUT_CYC  (`UIRB_TIMEOUT_MS*1000*`UIRB_CLK_MHZ)
`define UIRB_DEF_START    6'h02
`define UIRB_DEF_GAP      6'h02
`define UIRB_DEF_MINRX    16'h0001
`define UIRB_FLAG_BYTE    8'h7E
`define UIRB_PKT_MAX      64
`endif

// *** verilog/uirb_pkg.sv ***
// types shared by the bridge register set
`default_nettype none
package uirb_pkg;
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [7:0]  index;
		logic [15:0] value;
	} uirb_req_t;
	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} uirb_rsp_t;
	typedef enum logic [3:0] {
		TX_IDLE  = 4'b0001,
		TX_START = 4'b0010,
		TX_SEND  = 4'b0100,
		TX_GAP   = 4'b1000
	} uirb_tx_t;
	typedef enum logic [2:0] {
		SIP_IDLE = 3'b001,
		SIP_HIGH = 3'b010,
		SIP_LOW  = 3'b100
	} uirb_sip_t;
endpackage
`default_nettype wire

// *** verilog/uirb_top.sv ***
// register set, payload fifo and infrared data path of the bridge
// Functional notes
// - write request carries index and value, no data
// - read request returns one 16-bit register
// - bulk packets carry at most 64 bytes
// - mode bit 0 selects fast infrared
// - bit 1 picks 1.6us or 3/16 pulse
// - bit 2 drops packet gap, not SIR
// - bits 7:5 pick rate, reset one
// - bit 10 auto direction, else bit 11
// - bit 12 enables automatic interaction pulses
// - rising bit 13 sends one pulse
// - writing zero to bit 15 resets core
// - start flag count or default
// - packet gap setting or default
// - receive pin and configuration mode select
// - transmit and receive inversion
// - pulse high and low times
// - zero width registers use built-in widths
// - SIR receive idle abort, N x 50ms
// - fifo pointer clear, self clearing
// - transmit and receive activity status
`include "uirb_map.svh"
`timescale 1ns/10ps
`default_nettype none
module uirb_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4,
	localparam int AW = $clog2(DEPTH),
	localparam int CW = $clog2(DEPTH+1)
) (
	input  wire logic             core_clk,
	input  wire logic             rstn,
	input  wire logic             clear,
	input  wire logic             wValid,
	input  wire logic [WIDTH-1:0] wData,
	output logic                  wReady,
	output logic                  rValid,
	input  wire logic             rReady,
	output logic      [WIDTH-1:0] rData,
	output logic      [CW-1:0]    count
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr;
	logic [AW-1:0]    rdPtr;
	logic             push;
	logic             pop;
	assign wReady = (count != CW'(DEPTH));
	assign rValid = (count != '0);
	assign rData = mem[rdPtr];
	assign push = wValid && wReady;
	assign pop = rValid && rReady;
	always_ff @(posedge core_clk) begin
		if (push)
			mem[wrPtr] <= wData;
	end
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else if (clear) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (push)
				wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
			if (pop)
				rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
			count <= count + CW'(push) - CW'(pop);
		end
	end
endmodule // uirb_fifo

module uirb_top #(
	parameter int FIFO_DEPTH   = 4,
	parameter int TIMEOUT_TICK = `UIRB_TIMEOUT_CYC,
	localparam int CW = $clog2(FIFO_DEPTH+1)
) (
	input  wire logic            core_clk,
	input  wire logic            rstn,
	input  wire uirb_pkg::uirb_req_t ctlReq,
	output uirb_pkg::uirb_rsp_t  ctlRsp,
	input  wire logic            bulkOutValid,
	input  wire logic [7:0]      bulkOutData,
	output logic                 bulkOutReady,
	output logic                 bulkInValid,
	output logic      [7:0]      bulkInData,
	output logic                 bulkInLast,
	input  wire logic            bulkInReady,
	input  wire logic            fastReceiveInput,
	input  wire logic            slowReceiveInput,
	input  wire logic [3:0]      eepromLoadedBits,
	output logic                 irTxOut,
	output logic                 configModeOut,
	output logic      [11:0]     xcvrSetupOut,
	output logic                 pllSleepEnable
);
	import uirb_pkg::*;
	logic [15:0] mode, frame, sipTime, minRx, transmit_pulse_width;
	logic [14:0] fifoCtl;
	logic [11:0] transceiver_pin_setup;
	logic [13:0] resvBits;
	logic [3:0]  eeBits;
	logic        coreRst, fifoClr, sipReq, sipAuto;
	logic        txWay, next_txWay, rxActive, wayChangeAllowed;
	uirb_tx_t    txState;
	uirb_sip_t   sipState;
	logic [15:0] bitCnt, sipCnt, rxCnt, highRun;
	logic [5:0]  bitIdx, flagsLeft;
	logic [9:0]  txShift;
	logic [3:0]  rxIdx;
	logic [7:0]  rxShift, idleN;
	logic [31:0] tickCnt;
	logic        rxBusy, rxSeen, rxPush, txLevel;
	logic [6:0]  pktCnt;
	logic        fWValid, fWReady, fRValid, fRReady, txPop, bulkLoad;
	logic [7:0]  fWData, fRData;
	logic [CW-1:0] fCount;
	logic [CW:0] nextCount;

	function automatic logic hit(input uirb_req_t r, input logic [7:0] idx);
		return r.valid && r.write && (r.index == idx);
	endfunction
	function automatic logic [15:0] rate_cycles(input logic fir,
	                                            input logic [2:0] rate);
		int hz;
		hz = `UIRB_FIR_HZ;
		if (!fir) begin
			case (rate)
				3'h0: hz = 2400;
				3'h1: hz = 9600;
				3'h2: hz = 19200;
				3'h3: hz = 38400;
				3'h4: hz = 57600;
				3'h5: hz = 115200;
				3'h6: hz = 576000;
				default: hz = 1152000;
			endcase
		end
		return 16'(`UIRB_CLK_HZ / hz);
	endfunction
	function automatic logic [15:0] sip_cycles(input logic [8:0] n);
		logic [31:0] c;
		c = (32'(n) * `UIRB_CLK_MHZ) / `UIRB_SIP_REF_MHZ;
		return (c == 0) ? 16'h0001 : c[15:0];
	endfunction

	wire        firMode = mode[`UIRB_MODE_FIR];
	wire [2:0]  rate = mode[`UIRB_MODE_RATE_HI:`UIRB_MODE_RATE_LO];
	wire        sirMode = !firMode && !rate[2] | (!firMode && rate == 3'h4)
	                      | (!firMode && rate == 3'h5);
	wire [15:0] bitCyc = rate_cycles(firMode, rate);
	wire [15:0] fracW = 16'((32'(bitCyc) * `UIRB_SIR_FRAC_NUM)
	                    / `UIRB_SIR_FRAC_DEN);
	wire [15:0] pulseW = (transmit_pulse_width != '0) ? transmit_pulse_width
	                     : mode[`UIRB_MODE_SIR16] ? 16'(`UIRB_SIR_PULSE_CYC)
	                     : ((fracW == '0) ? 16'h0001 : fracW);
	wire [5:0]  startCnt = frame[7] ? frame[5:0] : `UIRB_DEF_START;
	wire [5:0]  gapCnt = frame[15] ? frame[13:8] : `UIRB_DEF_GAP;
	wire        backToBack = mode[`UIRB_MODE_BACK_TO_BACK_ENABLE] && !sirMode;
	wire [15:0] minW = (minRx != '0) ? minRx : `UIRB_DEF_MINRX;
	wire        rxLine = (transceiver_pin_setup[`UIRB_TRANSCEIVER_PIN_SETUP_FAST] ? fastReceiveInput
	                      : slowReceiveInput) ^ transceiver_pin_setup[`UIRB_TRANSCEIVER_PIN_SETUP_RECEIVE_INVERT];
	wire        pulseHit = rxLine && (highRun == minW - 16'h0001);
	wire        bitEnd = (bitCnt == bitCyc - 16'h0001);
	wire        charEnd = bitEnd && (bitIdx == 6'h09);
	wire        txActive = (txState != TX_IDLE);
	wire        sipBusy = (sipState != SIP_IDLE);

	// register writes; the request's setup stage carries index and value
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			mode <= `UIRB_RST_MODE;
			frame <= `UIRB_RST_FRAME;
			transceiver_pin_setup <= `UIRB_RST_TRANSCEIVER_PIN_SETUP;
			sipTime <= `UIRB_RST_SIP;
			minRx <= `UIRB_RST_MINRX;
			transmit_pulse_width <= `UIRB_RST_TRANSMIT_PULSE_WIDTH;
			fifoCtl <= `UIRB_RST_FIFOCTL;
			resvBits <= `UIRB_RST_TRANSFER_ACTIVITY_STATUS;
		end else begin
			if (hit(ctlReq, `UIRB_IDX_MODE))
				mode <= ctlReq.value;
			if (hit(ctlReq, `UIRB_IDX_FRAME))
				frame <= ctlReq.value;
			if (hit(ctlReq, `UIRB_IDX_TRANSCEIVER_PIN_SETUP))
				transceiver_pin_setup <= ctlReq.value[11:0];
			if (hit(ctlReq, `UIRB_IDX_SIP))
				sipTime <= ctlReq.value;
			if (hit(ctlReq, `UIRB_IDX_MINRX))
				minRx <= ctlReq.value;
			if (hit(ctlReq, `UIRB_IDX_TRANSMIT_PULSE_WIDTH))
				transmit_pulse_width <= ctlReq.value;
			if (hit(ctlReq, `UIRB_IDX_FIFOCTL))
				fifoCtl <= ctlReq.value[14:0];
			if (hit(ctlReq, `UIRB_IDX_STATUS))
				resvBits <= ctlReq.value[15:2];
		end
	end

	// one-cycle command pulses decoded from writes
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			coreRst <= 1'b0;
			fifoClr <= 1'b0;
			sipReq <= 1'b0;
		end else begin
			coreRst <= hit(ctlReq, `UIRB_IDX_MODE)
			           && !ctlReq.value[`UIRB_MODE_RST];
			fifoClr <= hit(ctlReq, `UIRB_IDX_FIFOCTL)
			           && ctlReq.value[`UIRB_FIFO_CLR];
			sipReq <= hit(ctlReq, `UIRB_IDX_MODE)
			          && ctlReq.value[`UIRB_MODE_SEND]
			          && !mode[`UIRB_MODE_SEND];
		end
	end

	// read answers one cycle after the request; writes answer with zero
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctlRsp <= '0;
		end else begin
			ctlRsp.valid <= ctlReq.valid;
			ctlRsp.data <= '0;
			if (ctlReq.valid && !ctlReq.write) begin
				case (ctlReq.index)
					`UIRB_IDX_MODE:
						ctlRsp.data <= {1'b1, wayChangeAllowed, mode[13:0]};
					`UIRB_IDX_FRAME: ctlRsp.data <= frame;
					`UIRB_IDX_TRANSCEIVER_PIN_SETUP: ctlRsp.data <= {eeBits, transceiver_pin_setup};
					`UIRB_IDX_SIP: ctlRsp.data <= sipTime;
					`UIRB_IDX_MINRX: ctlRsp.data <= minRx;
					`UIRB_IDX_TRANSMIT_PULSE_WIDTH: ctlRsp.data <= transmit_pulse_width;
					`UIRB_IDX_FIFOCTL: ctlRsp.data <= {1'b0, fifoCtl};
					`UIRB_IDX_STATUS:
						ctlRsp.data <= {resvBits, rxActive, txActive};
					default: ctlRsp.data <= '0;
				endcase
			end
		end
	end

	// direction: hardware picks it, or software through the direction bit
	always_comb begin
		next_txWay = mode[`UIRB_MODE_DIR];
		if (mode[`UIRB_MODE_DTD]) begin
			next_txWay = txWay;
			if (bulkOutValid && !rxActive)
				next_txWay = 1'b1;
			else if (!txActive && fCount == '0 && !bulkOutValid)
				next_txWay = 1'b0;
		end
	end
	assign fWValid = txWay ? (bulkOutValid && bulkOutReady) : rxPush;
	assign fWData = txWay ? bulkOutData : rxShift;
	assign bulkLoad = !txWay && fRValid && (!bulkInValid || bulkInReady);
	assign fRReady = txPop || bulkLoad;
	assign nextCount = (CW+1)'(fCount) + (CW+1)'(fWValid && fWReady)
	                   - (CW+1)'(fRReady && fRValid);
	assign txPop = txWay && fRValid && !sipBusy
	               && ((txState == TX_IDLE && (sirMode || startCnt == '0))
	               || (txState == TX_START && charEnd && flagsLeft == '0)
	               || (txState == TX_SEND && charEnd));

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			txWay <= 1'b0;
			bulkOutReady <= 1'b0;
			wayChangeAllowed <= 1'b1;
		end else begin
			txWay <= next_txWay;
			bulkOutReady <= next_txWay && !coreRst && !fifoClr
			                && (nextCount < (CW+1)'(FIFO_DEPTH));
			wayChangeAllowed <= !txActive && !rxActive && fCount == '0
			                    && !bulkInValid;
		end
	end

	uirb_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk (core_clk),
		.rstn     (rstn),
		.clear    (fifoClr || coreRst),
		.wValid   (fWValid),
		.wData    (fWData),
		.wReady   (fWReady),
		.rValid   (fRValid),
		.rReady   (fRReady),
		.rData    (fRData),
		.count    (fCount)
	);

	// bulk-in stage; a packet ends at 64 bytes or when the fifo runs dry
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			bulkInValid <= 1'b0;
			bulkInData <= '0;
			bulkInLast <= 1'b0;
			pktCnt <= '0;
		end else if (coreRst || fifoClr) begin
			bulkInValid <= 1'b0;
			bulkInLast <= 1'b0;
			pktCnt <= '0;
		end else if (bulkLoad) begin
			bulkInValid <= 1'b1;
			bulkInData <= fRData;
			bulkInLast <= (pktCnt == 7'(`UIRB_PKT_MAX - 1))
			              || (fCount == CW'(1) && !fWValid);
			pktCnt <= (bulkInLast && bulkInValid) ? 7'h01 : pktCnt + 7'h01;
		end else if (bulkInReady) begin
			bulkInValid <= 1'b0;
			if (bulkInLast)
				pktCnt <= '0;
		end
	end

	// transmitter: start flags, characters, then the packet gap
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			txState <= TX_IDLE;
			txShift <= '1;
			bitCnt <= '0;
			bitIdx <= '0;
			flagsLeft <= '0;
			sipAuto <= 1'b0;
		end else if (coreRst) begin
			txState <= TX_IDLE;
			bitCnt <= '0;
			bitIdx <= '0;
			sipAuto <= 1'b0;
		end else begin
			sipAuto <= 1'b0;
			bitCnt <= bitEnd ? '0 : bitCnt + 16'h0001;
			if (bitEnd)
				bitIdx <= bitIdx + 6'h01;
			if (txState != TX_IDLE && bitEnd)
				txShift <= {1'b1, txShift[9:1]};
			case (txState)
				TX_IDLE: begin
					bitCnt <= '0;
					bitIdx <= '0;
					if (txPop) begin
						txShift <= {1'b1, fRData, 1'b0};
						txState <= TX_SEND;
					end else if (txWay && fRValid && !sipBusy) begin
						txShift <= {1'b1, `UIRB_FLAG_BYTE, 1'b0};
						flagsLeft <= startCnt - 6'h01;
						txState <= TX_START;
					end
				end
				TX_START, TX_SEND: begin
					if (charEnd) begin
						bitIdx <= '0;
						if (txState == TX_START && flagsLeft != '0) begin
							txShift <= {1'b1, `UIRB_FLAG_BYTE, 1'b0};
							flagsLeft <= flagsLeft - 6'h01;
						end else if (txPop) begin
							txShift <= {1'b1, fRData, 1'b0};
							txState <= TX_SEND;
						end else begin
							sipAuto <= 1'b1;
							txState <= backToBack ? TX_IDLE : TX_GAP;
						end
					end
				end
				TX_GAP: begin
					if (bitIdx >= gapCnt)
						txState <= TX_IDLE;
				end
				default: txState <= TX_IDLE;
			endcase
		end
	end
	always_comb begin
		txLevel = 1'b0;
		if (txState == TX_START || txState == TX_SEND)
			txLevel = !txShift[0] && (!sirMode || bitCnt < pulseW);
	end

	// interaction pulse: high time then enforced low time
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sipState <= SIP_IDLE;
			sipCnt <= '0;
		end else if (coreRst) begin
			sipState <= SIP_IDLE;
			sipCnt <= '0;
		end else begin
			sipCnt <= sipCnt + 16'h0001;
			case (sipState)
				SIP_IDLE: begin
					sipCnt <= '0;
					if (sipReq || (sipAuto && mode[`UIRB_MODE_AUTO_PULSE_ENABLE]))
						sipState <= SIP_HIGH;
				end
				SIP_HIGH: begin
					if (sipCnt == sip_cycles({2'b00, sipTime[6:0]}) - 16'h0001) begin
						sipCnt <= '0;
						sipState <= SIP_LOW;
					end
				end
				SIP_LOW: begin
					if (sipCnt == sip_cycles(sipTime[15:7]) - 16'h0001)
						sipState <= SIP_IDLE;
				end
				default: sipState <= SIP_IDLE;
			endcase
		end
	end

	// receiver: a qualified pulse inside a bit period marks a zero
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			highRun <= '0;
			rxBusy <= 1'b0;
			rxSeen <= 1'b0;
			rxCnt <= '0;
			rxIdx <= '0;
			rxShift <= '0;
			rxPush <= 1'b0;
		end else if (coreRst) begin
			highRun <= '0;
			rxBusy <= 1'b0;
			rxPush <= 1'b0;
		end else begin
			rxPush <= 1'b0;
			highRun <= rxLine ? ((highRun == 16'hFFFF) ? highRun
			           : highRun + 16'h0001) : '0;
			if (!rxBusy) begin
				if (pulseHit && !txWay) begin
					rxBusy <= 1'b1;
					// start half a bit in, so each window is centred on
					// the pulse that opens its bit
					rxCnt <= bitCyc >> 1;
					rxIdx <= '0;
					rxSeen <= 1'b0;
				end
			end else if (rxCnt == bitCyc - 16'h0001) begin
				rxCnt <= '0;
				rxSeen <= 1'b0;
				rxIdx <= rxIdx + 4'h1;
				if (rxIdx != '0 && rxIdx < 4'h9)
					rxShift <= {!(rxSeen || pulseHit), rxShift[7:1]};
				if (rxIdx == 4'h9) begin
					rxBusy <= 1'b0;
					rxPush <= 1'b1;
				end
			end else begin
				rxCnt <= rxCnt + 16'h0001;
				rxSeen <= rxSeen || pulseHit;
			end
		end
	end

	// activity flag and the SIR idle abort
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rxActive <= 1'b0;
			tickCnt <= '0;
			idleN <= '0;
		end else if (coreRst || txWay) begin
			rxActive <= 1'b0;
			tickCnt <= '0;
			idleN <= '0;
		end else if (pulseHit) begin
			rxActive <= 1'b1;
			tickCnt <= '0;
			idleN <= '0;
		end else if (rxActive && !rxBusy) begin
			if (!sirMode) begin
				rxActive <= 1'b0;
			end else if (tickCnt == 32'(TIMEOUT_TICK - 1)) begin
				tickCnt <= '0;
				idleN <= idleN + 8'h01;
				if (idleN + 8'h01 >= fifoCtl[7:0])
					rxActive <= 1'b0;
			end else begin
				tickCnt <= tickCnt + 32'h0000_0001;
			end
		end
	end

	// pin and strap outputs
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			irTxOut <= 1'b0;
			configModeOut <= 1'b0;
			xcvrSetupOut <= `UIRB_RST_TRANSCEIVER_PIN_SETUP;
			pllSleepEnable <= 1'b1;
		end else begin
			irTxOut <= (txLevel || sipState == SIP_HIGH)
			           ^ transceiver_pin_setup[`UIRB_TRANSCEIVER_PIN_SETUP_TRANSMIT_INVERT];
			configModeOut <= transceiver_pin_setup[`UIRB_TRANSCEIVER_PIN_SETUP_CFG];
			xcvrSetupOut <= transceiver_pin_setup;
			pllSleepEnable <= mode[`UIRB_MODE_PLL];
		end
	end
	always_ff @(posedge core_clk) begin
		eeBits <= eepromLoadedBits;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	rsp_timing_a: assert property (ctlReq.valid |=> ctlRsp.valid)
		else $error("request not answered next cycle");
	write_nodata_a: assert property (ctlReq.valid && ctlReq.write |=> ctlRsp.data == '0)
		else $error("write answer carried data");
	reset_read_a: assert property (ctlReq.valid && !ctlReq.write && ctlReq.index == `UIRB_IDX_MODE |=> ctlRsp.data[15])
		else $error("reset bit not read as one");
	soft_reset_a: assert property (hit(ctlReq, `UIRB_IDX_MODE) && !ctlReq.value[15] |=> coreRst ##1 txState == TX_IDLE && !rxActive)
		else $error("soft reset did not idle the core");
	sip_edge_a: assert property (hit(ctlReq, `UIRB_IDX_MODE) && ctlReq.value[13] && ctlReq.value[15] && !mode[13] && sipState == SIP_IDLE |=> sipReq ##1 sipState == SIP_HIGH)
		else $error("rising send bit gave no pulse");
	fifo_clear_a: assert property (hit(ctlReq, `UIRB_IDX_FIFOCTL) && ctlReq.value[15] |=> fifoClr ##1 fCount == '0)
		else $error("fifo not cleared");
	status_tx_a: assert property (ctlReq.valid && !ctlReq.write && ctlReq.index == `UIRB_IDX_STATUS |=> ctlRsp.data[1:0] == {$past(rxActive), $past(txActive)})
		else $error("activity status mismatch");
	way_manual_a: assert property (!mode[`UIRB_MODE_DTD] |=> txWay == $past(mode[`UIRB_MODE_DIR]))
		else $error("direction not taken from bit");
	fir_rate_a: assert property (firMode |-> bitCyc == 16'(`UIRB_CLK_HZ / `UIRB_FIR_HZ))
		else $error("fast mode bit time wrong");
	sir_pulse_a: assert property (sirMode && mode[1] && transmit_pulse_width == '0 |-> pulseW == 16'(`UIRB_SIR_PULSE_CYC))
		else $error("fixed pulse width wrong");
	tx_idle_a: assert property (txState == TX_IDLE && sipState != SIP_HIGH |=> irTxOut == $past(transceiver_pin_setup[`UIRB_TRANSCEIVER_PIN_SETUP_TRANSMIT_INVERT]))
		else $error("idle transmit level wrong");
	tx_frame_c: cover property (txState == TX_SEND ##1 txState == TX_GAP);
	rx_byte_c: cover property (rxPush);
	sip_pulse_c: cover property (sipState == SIP_HIGH ##1 sipState == SIP_LOW);
	rx_abort_c: cover property (rxActive && sirMode ##1 !rxActive && !txWay);
endmodule // uirb_top
`default_nettype wire

// *** tb/uirb_ir_partner.sv ***
// infrared transceiver model: counts transmit pulses, rests receive lines
`timescale 1ns/10ps
`default_nettype none
module uirb_ir_partner (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        irTxOut,
	output logic             fastLine,
	output logic             slowLine,
	output logic [15:0]      pulseCount,
	output logic [15:0]      lastWidth
);
	logic [15:0] run;
	logic        light = 1'b0;
	// lines rest low for active-high reception; only the fast one lights
	assign fastLine = light;
	assign slowLine = 1'b0;
	// one SIR character: a light pulse of w cycles opens every zero bit
	task automatic irByte(input logic [7:0] d, input int bitCyc,
	                      input int w);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			light = !f[i];
			repeat (w) @(posedge core_clk);
			#1 light = 1'b0;
			repeat (bitCyc - w) @(posedge core_clk);
			#1;
		end
	endtask
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pulseCount <= 16'h0000;
			lastWidth  <= 16'h0000;
			run        <= 16'h0000;
		end else if (irTxOut === 1'b1) begin
			run <= run + 16'h0001;
		end else if (run != 16'h0000) begin
			pulseCount <= pulseCount + 16'h0001;
			lastWidth  <= run;
			run        <= 16'h0000;
		end
	end
endmodule // uirb_ir_partner
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench of the bridge register set
`include "uirb_map.svh"
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import uirb_pkg::*;
	localparam logic [15:0] M = 16'h8764;
	logic        core_clk, rstn, outValid, outReady, inValid, inReady;
	logic        inLast, fastLine, slowLine, irTxOut, cfgMode, pllSleep;
	logic [7:0]  outData, inData, b;
	logic [3:0]  eeBits;
	logic [11:0] xcvrOut;
	logic [15:0] pulseCount, lastWidth, rd, p0, v;
	logic [15:0] rv [9];
	logic [8:0]  inByte;
	uirb_req_t   req;
	uirb_rsp_t   rsp;
	int          n_fail, num_checks, acc, nIn;
	bit          ok;
	uirb_top #(.FIFO_DEPTH(4), .TIMEOUT_TICK(20)) u_uirb_top (
		.core_clk(core_clk), .rstn(rstn), .ctlReq(req), .ctlRsp(rsp),
		.bulkOutValid(outValid), .bulkOutData(outData),
		.bulkOutReady(outReady), .bulkInValid(inValid), .bulkInData(inData),
		.bulkInLast(inLast), .bulkInReady(inReady),
		.fastReceiveInput(fastLine), .slowReceiveInput(slowLine),
		.eepromLoadedBits(eeBits), .irTxOut(irTxOut),
		.configModeOut(cfgMode), .xcvrSetupOut(xcvrOut),
		.pllSleepEnable(pllSleep));
	uirb_ir_partner u_uirb_ir_partner (.core_clk(core_clk), .rstn(rstn),
		.irTxOut(irTxOut),
		.fastLine(fastLine), .slowLine(slowLine), .pulseCount(pulseCount),
		.lastWidth(lastWidth));
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk) inReady <= #1 1'($urandom);
	// bulk-in sink: count every byte taken, keep the latest one with its last flag
	always @(posedge core_clk) begin
		if (!rstn)
			nIn <= 0;
		else if (inValid === 1'b1 && inReady === 1'b1) begin
			nIn <= nIn + 1;
			inByte <= {inLast, inData};
		end
	end
	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] i, input logic [15:0] d);
		req = '{1'b1, 1'b1, i, d};
		tick();
		req.valid = 1'b0;
		tick();
	endtask
	task automatic rdReg(input logic [7:0] i);
		bit got;
		req = '{1'b1, 1'b0, i, 16'h0000};
		tick();
		req.valid = 1'b0;
		rd = 16'hxxxx;
		got = 0;
		for (int k = 0; k < 3 && !got; k++) begin
			if (rsp.valid === 1'b1) begin
				rd = rsp.data;
				got = 1;
			end else tick();
		end
		tick();
	endtask
	task automatic send(input logic [7:0] d, output bit taken);
		tick();
		outValid = 1'b1;
		outData = d;
		taken = 0;
		for (int k = 0; k < 20 && !taken; k++) begin
			@(posedge core_clk);
			taken = (outReady === 1'b1);
		end
		#1;
		outValid = 1'b0;
	endtask
	task automatic waitIdle();
		repeat (4) tick();
		for (int k = 0; k < 600; k++) begin
			rdReg(`UIRB_IDX_STATUS);
			if (rd[0] === 1'b0) break;
			repeat (40) tick();
		end
		chk({15'h0000, rd[0]}, 16'h0000);
	endtask
	// pulse count of one SIR character: start bit plus every zero bit
	function automatic logic [15:0] pulses(input logic [7:0] d);
		return 16'h0001 + 16'(8 - $countones(d));
	endfunction
	// rate 3 bit time is 520 cycles; fixed pulse is 1.6 us
	function automatic logic [15:0] expW(input bit s);
		return s ? 16'h0020 : 16'(520 * 3 / 16);
	endfunction
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge core_clk);
		n_fail++;
		final_report();
	end
	initial begin
		rstn = 1'b0;
		req = '0;
		outValid = 1'b0;
		outData = 8'h00;
		eeBits = 4'h0;
		void'($urandom(96814));
		eeBits = 4'($urandom);
		repeat (20) tick();
		rstn = 1'b1;
		tick();
		chk({4'h0, xcvrOut}, 16'h0100);
		chk({15'h0000, pllSleep}, 16'h0001);
		rv = '{16'hD524, 16'h0000, {eeBits, 12'h100}, 16'hAA4C, 16'h0000,
			16'h0000, 16'h400A, 16'h0028, 16'h0000};
		for (int i = 0; i < 9; i++) begin
			rdReg(8'(i));
			chk(rd, rv[i]);
		end
		$display("test reset done");
		wr(`UIRB_IDX_MODE, 16'h9724);
		foreach (rv[i]) if (i == 1 || (i >= 3 && i <= 5)) begin
			for (int k = 0; k < 3; k++) begin
				v = (k == 0) ? 16'($urandom) : (k == 1) ? 16'hFFFF : 16'h0000;
				wr(8'(i), v);
				rdReg(8'(i));
				chk(rd, v);
			end
		end
		v = 16'($urandom);
		wr(`UIRB_IDX_TRANSCEIVER_PIN_SETUP, v);
		chk({4'h0, xcvrOut}, {4'h0, v[11:0]});
		chk({15'h0000, cfgMode}, {15'h0000, v[2]});
		rdReg(`UIRB_IDX_TRANSCEIVER_PIN_SETUP);
		chk(rd, {eeBits, v[11:0]});
		wr(`UIRB_IDX_TRANSCEIVER_PIN_SETUP, 16'h0100);
		wr(`UIRB_IDX_MODE, 16'h3724);
		tick();
		rdReg(`UIRB_IDX_MODE);
		chk(rd, 16'hF724);
		wr(`UIRB_IDX_FIFOCTL, 16'hC00A);
		rdReg(`UIRB_IDX_FIFOCTL);
		chk(rd, 16'h400A);
		$display("test registers done");
		wr(`UIRB_IDX_MODE, M & 16'h7FFF);
		wr(`UIRB_IDX_SIP, 16'hAA4C);
		p0 = pulseCount;
		repeat (2) begin
			wr(`UIRB_IDX_MODE, M | 16'h2000);
			repeat (200) tick();
			chk(pulseCount - p0, 16'h0001);
		end
		v = 16'(16'h004C * `UIRB_CLK_MHZ / `UIRB_SIP_REF_MHZ);
		ok = lastWidth + 16'h0001 >= v && lastWidth <= v + 16'h0001;
		chk({15'h0000, ok}, 16'h0001);
		wr(`UIRB_IDX_MODE, M);
		$display("test pulse request done");
		for (int k = 0; k < 4; k++) begin
			b = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
			v = k[0] ? 16'h0002 : 16'h0000;
			wr(`UIRB_IDX_MODE, (M | v) & 16'h7FFF);
			p0 = pulseCount;
			send(b, ok);
			chk({15'h0000, ok}, 16'h0001);
			waitIdle();
			chk(pulseCount - p0, pulses(b));
			v = expW(k[0]);
			ok = lastWidth + 16'h0002 >= v && lastWidth <= v + 16'h0002;
			chk({15'h0000, ok}, 16'h0001);
		end
		$display("test sir transmit done");
		wr(`UIRB_IDX_FIFOCTL, 16'h4014);
		for (int k = 0; k < 2; k++) begin
			b = 8'($urandom);
			acc = nIn;
			wr(`UIRB_IDX_TRANSCEIVER_PIN_SETUP, k ? 16'h0108 : 16'h0100);
			u_uirb_ir_partner.irByte(b, 520, 97);
			rdReg(`UIRB_IDX_STATUS);
			chk({15'h0000, rd[1]}, 16'(k));
			repeat (300) tick();
			rdReg(`UIRB_IDX_STATUS);
			chk({15'h0000, rd[1]}, 16'h0000);
			chk(16'(nIn - acc), 16'(k));
			if (k == 1)
				chk({7'h00, inByte}, {7'h01, b});
		end
		$display("test sir receive done");
		wr(`UIRB_IDX_MODE, M & 16'hFBFF);
		send(8'h55, ok);
		chk({15'h0000, ok}, 16'h0000);
		wr(`UIRB_IDX_MODE, 16'h0BA4);
		acc = 0;
		repeat (8) begin
			send(8'h00, ok);
			acc += int'(ok);
		end
		chk(16'(acc >= 4 && acc <= 6), 16'h0001);
		rdReg(`UIRB_IDX_STATUS);
		chk({15'h0000, rd[0]}, 16'h0001);
		wr(`UIRB_IDX_MODE, 16'h0BA4);
		rdReg(`UIRB_IDX_STATUS);
		chk({15'h0000, rd[0]}, 16'h0000);
		$display("test fill and abort done");
		final_report();
	end
endmodule // testbench
`default_nettype wire
